// ### rtl/ltf_top.v
// Purpose: LIN trigger and frame filter behind an AHB-Lite register slave
// Assumes: Decoder strobes are single-cycle pulses on core_clk
// Notes: Writes take no wait state, reads take one
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`include "ltf_map.vh"
module ltf_top #(
  parameter NB = 4,
  parameter NFT = 8,
  parameter NET = 8
) (
  core_clk,
  rst,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hready,
  hwdata,
  hrdata,
  hreadyout,
  hresp,
  dec_sync_stop,
  dec_id_valid,
  dec_id,
  dec_data_valid,
  dec_data,
  dec_wake,
  dec_chk_err,
  dec_par_err,
  dec_sync_err,
  dec_frame_end,
  dec_frame_type,
  dec_frame_errs,
  trig_pulse,
  frame_pass,
  frame_pass_valid,
  idle_low_polarity
);
  input wire core_clk;
  input wire rst;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire hready;
  input wire [31:0] hwdata;
  output reg [31:0] hrdata;
  output reg hreadyout;
  output reg hresp;
  input wire [NB-1:0] dec_sync_stop;
  input wire [NB-1:0] dec_id_valid;
  input wire [8*NB-1:0] dec_id;
  input wire [NB-1:0] dec_data_valid;
  input wire [8*NB-1:0] dec_data;
  input wire [NB-1:0] dec_wake;
  input wire [NB-1:0] dec_chk_err;
  input wire [NB-1:0] dec_par_err;
  input wire [NB-1:0] dec_sync_err;
  input wire [NB-1:0] dec_frame_end;
  input wire [3*NB-1:0] dec_frame_type;
  input wire [NET*NB-1:0] dec_frame_errs;
  output wire trig_pulse;
  output wire [NB-1:0] frame_pass;
  output wire [NB-1:0] frame_pass_valid;
  output wire [NB-1:0] idle_low_polarity;

  // Relation from less-than and equal flags, shared by identifier and data
  function relop;
    input [2:0] op;
    input lt;
    input eq;
    begin
      case (op)
        `LTF_EQUAL_OP: relop = eq;
        `LTF_NOT_EQUAL_OP: relop = ~eq;
        `LTF_LESS_OP: relop = lt;
        `LTF_LESS_EQUAL_OP: relop = lt | eq;
        `LTF_GREATER_OP: relop = ~lt & ~eq;
        `LTF_GREATER_EQUAL_OP: relop = ~lt;
        default: relop = 1'b0;
      endcase
    end
  endfunction

  // Bus slave state
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg rd_wait_q;
  reg [7:0] rd_addr_q;
  wire acc = hsel & htrans[1] & hready;
  wire we = wr_pend_q;
  wire bus_we = we & (wr_addr_q[7:6] == `LTF_BUS_BASE >> 6);

  // Trigger settings
  reg [2:0] trig_type_q;
  reg [2:0] err_en_q;
  reg [2:0] data_op_q;
  reg [31:0] data_pat_q;
  reg [12:0] skip_q;
  reg [1:0] len_q;
  reg [2:0] id_op_q;
  reg [5:0] id_low_q;
  reg [5:0] id_high_q;
  reg [1:0] src_q;
  reg [15:0] trig_cnt_q;
  reg [5:0] last_id_q;

  // Address and data phase capture, one wait state on reads
  always @(posedge core_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_wait_q <= 1'b0;
      rd_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= acc & hwrite;
      rd_wait_q <= acc & ~hwrite;
      hreadyout <= ~(acc & ~hwrite);
      if (acc) begin
        wr_addr_q <= {haddr[7:2], 2'b00};
        rd_addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Trigger setting writes
  always @(posedge core_clk) begin
    if (rst) begin
      trig_type_q <= `LTF_START_OF_FRAME_TYPE;
      err_en_q <= `LTF_ERR_EN_RST;
      data_op_q <= `LTF_EQUAL_OP;
      data_pat_q <= 32'h00000000;
      skip_q <= `LTF_SKIP_RST;
      len_q <= `LTF_LEN_RST;
      id_op_q <= `LTF_EQUAL_OP;
      id_low_q <= `LTF_ID_LOW_RST;
      id_high_q <= `LTF_ID_HIGH_RST;
      src_q <= 2'h0;
    end else if (we) begin
      case (wr_addr_q)
        `LTF_TRIG_TYPE: trig_type_q <= hwdata[2:0];
        `LTF_TRIG_ERR_EN: err_en_q <= hwdata[2:0];
        `LTF_DATA_OP: data_op_q <= hwdata[2:0];
        `LTF_DATA_PAT: data_pat_q <= hwdata;
        `LTF_DATA_CFG: begin
          skip_q <= (hwdata[12:0] == 13'h0000) ? 13'h0001 : hwdata[12:0];
          len_q <= hwdata[`LTF_LEN_LSB+1:`LTF_LEN_LSB];
        end
        `LTF_ID_OP: id_op_q <= hwdata[2:0];
        `LTF_ID_LOW: id_low_q <= hwdata[5:0];
        `LTF_ID_HIGH: id_high_q <= hwdata[5:0];
        `LTF_TRIG_SRC: src_q <= hwdata[1:0];
        default: src_q <= src_q;
      endcase
    end
  end

  // Events of the selected trigger source
  wire s_sof = dec_sync_stop[src_q];
  wire s_idv = dec_id_valid[src_q];
  wire [5:0] s_id = dec_id[8*src_q +: 6];
  wire s_dv = dec_data_valid[src_q];
  wire [7:0] s_data = dec_data[8*src_q +: 8];
  wire s_wake = dec_wake[src_q];
  wire s_chk = dec_chk_err[src_q];
  wire s_par = dec_par_err[src_q];
  wire s_syn = dec_sync_err[src_q];

  // Identifier condition, upper bound only for range operators
  reg id_hit;
  always @* begin
    case (id_op_q)
      `LTF_WITHIN_BOUNDS_OP: id_hit = (s_id >= id_low_q) && (s_id <= id_high_q);
      `LTF_OUTSIDE_BOUNDS_OP: id_hit = (s_id < id_low_q) || (s_id > id_high_q);
      default: id_hit = relop(id_op_q, s_id < id_low_q, s_id == id_low_q);
    endcase
  end

  // Data condition, byte list compared most significant byte first
  reg [12:0] dcnt_q;
  reg d_dec_q;
  reg d_lt_q;
  reg id_ok_q;
  wire [12:0] bidx = dcnt_q - skip_q;
  wire d_act = s_dv && (dcnt_q >= skip_q) && (bidx <= {11'h000, len_q});
  wire [7:0] pbyte = data_pat_q[8*bidx[1:0] +: 8];
  wire lt_f = d_dec_q ? d_lt_q : (s_data < pbyte);
  wire eq_f = ~d_dec_q & (s_data == pbyte);
  wire d_last = d_act && (bidx[1:0] == len_q);
  wire data_hit = d_last & relop(data_op_q, lt_f, eq_f);

  // Frame tracking of identifier and data progress
  always @(posedge core_clk) begin
    if (rst) begin
      dcnt_q <= 13'h0000;
      d_dec_q <= 1'b0;
      d_lt_q <= 1'b0;
      id_ok_q <= 1'b0;
    end else if (s_sof) begin
      dcnt_q <= 13'h0000;
      d_dec_q <= 1'b0;
      d_lt_q <= 1'b0;
      id_ok_q <= 1'b0;
    end else begin
      if (s_idv)
        id_ok_q <= id_hit;
      if (s_dv && dcnt_q != 13'h1FFF)
        dcnt_q <= dcnt_q + 13'h0001;
      if (d_act && !d_dec_q && s_data != pbyte) begin
        d_dec_q <= 1'b1;
        d_lt_q <= s_data < pbyte;
      end
    end
  end

  // Trigger decision per type
  reg fire;
  always @* begin
    case (trig_type_q)
      `LTF_START_OF_FRAME_TYPE: fire = s_sof;
      `LTF_IDENT_TYPE: fire = s_idv & id_hit;
      `LTF_ID_AND_PAYLOAD_TYPE: fire = data_hit & id_ok_q;
      `LTF_WAKE_FRAME_TYPE: fire = s_wake;
      `LTF_ERROR_CONDITION_TYPE: fire = (s_chk & err_en_q[`LTF_CHECKSUM_FAULT_BIT])
        | (s_par & err_en_q[`LTF_ID_PARITY_FAULT_BIT])
        | (s_syn & err_en_q[`LTF_SYNC_FAULT_BIT]);
      default: fire = 1'b0;
    endcase
  end

  // Trigger pulse and status
  reg trig_q;
  always @(posedge core_clk) begin
    if (rst) begin
      trig_q <= 1'b0;
      trig_cnt_q <= 16'h0000;
      last_id_q <= 6'h00;
    end else begin
      trig_q <= fire;
      if (fire)
        trig_cnt_q <= trig_cnt_q + 16'h0001;
      if (s_idv)
        last_id_q <= s_id;
    end
  end
  assign trig_pulse = trig_q;

  // Per-bus filter enables, commands and polarity
  wire [16*NB-1:0] flt_en_w;
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : bus
      reg [15:0] en_q;
      reg pol_q;
      reg pass_q;
      reg pvld_q;
      wire sel = bus_we && (wr_addr_q[5:4] == g);
      wire [NET-1:0] errs = dec_frame_errs[NET*g +: NET];
      wire [2:0] ft = dec_frame_type[3*g +: 3];
      always @(posedge core_clk) begin
        if (rst) begin
          en_q <= `LTF_FLT_EN_RST;
          pol_q <= 1'b0;
        end else if (sel) begin
          case (wr_addr_q[3:2])
            `LTF_FLT_EN: en_q <= hwdata[15:0];
            `LTF_FLT_CMD: begin
              if (hwdata[`LTF_CMD_RESET_BIT])
                en_q <= `LTF_FLT_EN_RST;
              else if (hwdata[`LTF_CMD_SELECT_ALL_BIT])
                en_q <= 16'hFFFF;
              else if (hwdata[`LTF_CMD_DESELECT_ALL_BIT])
                en_q <= 16'h0000;
              else if (hwdata[`LTF_CMD_INVERT_BIT])
                en_q <= ~en_q;
            end
            `LTF_FLT_IDX: en_q[{hwdata[8], hwdata[2:0]}] <= hwdata[16];
            default: pol_q <= hwdata[0];
          endcase
        end
      end
      // Frame verdict at frame end
      always @(posedge core_clk) begin
        if (rst) begin
          pass_q <= 1'b0;
          pvld_q <= 1'b0;
        end else begin
          pvld_q <= dec_frame_end[g];
          if (dec_frame_end[g])
            pass_q <= en_q[ft] & ((errs == {NET{1'b0}}) | (|(errs & en_q[15:8])));
        end
      end
      assign flt_en_w[16*g +: 16] = en_q;
      assign frame_pass[g] = pass_q;
      assign frame_pass_valid[g] = pvld_q;
      assign idle_low_polarity[g] = pol_q;
    end
  endgenerate

  // Read data loaded in the wait cycle
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    if (rd_addr_q[7:6] == `LTF_BUS_BASE >> 6) begin
      if (rd_addr_q[3:2] == `LTF_FLT_EN)
        rd_d = {16'h0000, flt_en_w[16*rd_addr_q[5:4] +: 16]};
      else if (rd_addr_q[3:2] == `LTF_BUS_CFG)
        rd_d = {31'h00000000, idle_low_polarity[rd_addr_q[5:4]]};
    end else begin
      case (rd_addr_q)
        `LTF_TRIG_TYPE: rd_d = {29'h00000000, trig_type_q};
        `LTF_TRIG_ERR_EN: rd_d = {29'h00000000, err_en_q};
        `LTF_DATA_OP: rd_d = {29'h00000000, data_op_q};
        `LTF_DATA_PAT: rd_d = data_pat_q;
        `LTF_DATA_CFG: rd_d = {14'h0000, len_q, 3'h0, skip_q};
        `LTF_ID_OP: rd_d = {29'h00000000, id_op_q};
        `LTF_ID_LOW: rd_d = {26'h0000000, id_low_q};
        `LTF_ID_HIGH: rd_d = {26'h0000000, id_high_q};
        `LTF_TRIG_SRC: rd_d = {30'h00000000, src_q};
        `LTF_TRIG_STATUS: rd_d = {10'h000, last_id_q, trig_cnt_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // Read data register
  always @(posedge core_clk) begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (rd_wait_q)
      hrdata <= rd_d;
  end
endmodule

// ### shared/ltf_map.vh
// Purpose: Offsets, fields, reset values and counts of the trigger and filter block
// Assumes: AHB-Lite word access, one register per aligned word
// Notes: Per-bus filter words sit at LTF_BUS_BASE + 16 * bus index
// How it works
// - Five trigger types selectable; start of frame after reset.
// - Start-of-frame type fires at the stop bit closing the sync field.
// - Identifier type fires on a match of single value or range.
// - Combined type fires when identifier and data both match in one frame.
// - Checksum fault triggers in error type when enabled; enabled after reset.
// - Identifier parity fault, bits 6 and 7, triggers when enabled; enabled after reset.
// - Sync field fault triggers in error type when enabled; enabled after reset.
// - Data compared to one pattern with six relational operators; equal default.
// - Data pattern is a byte list; same setting is the single pattern only, never a low bound.
// - Data check starts after 1 to 8191 data events skipped; default 1.
// - Identifier offers six relations plus in and out of range; equal default.
// - Upper identifier bound used only by the two range operators.
// - Four independent bus indices, each with its own filter settings.
// - Select-all command enables every frame and error type at once.
// - Deselect-all command disables every frame and error type at once.
// - Invert command toggles every frame and error type enable.
// - Filter enables writable by index word or by bitmap, same storage.
// - Polarity setting per bus selects idle high or low; idle high default.
// - Filter reset returns every frame and error enable to its default.
`ifndef LTF_MAP_VH
`define LTF_MAP_VH
// Global trigger registers
`define LTF_TRIG_TYPE 8'h00
`define LTF_TRIG_ERR_EN 8'h04
`define LTF_DATA_OP 8'h08
`define LTF_DATA_PAT 8'h0C
`define LTF_DATA_CFG 8'h10
`define LTF_ID_OP 8'h14
`define LTF_ID_LOW 8'h18
`define LTF_ID_HIGH 8'h1C
`define LTF_TRIG_SRC 8'h20
`define LTF_TRIG_STATUS 8'h24
// Per-bus filter block
`define LTF_BUS_BASE 8'h40
`define LTF_FLT_EN 2'h0
`define LTF_FLT_CMD 2'h1
`define LTF_FLT_IDX 2'h2
`define LTF_BUS_CFG 2'h3
// Trigger types
`define LTF_START_OF_FRAME_TYPE 3'h0
`define LTF_IDENT_TYPE 3'h1
`define LTF_ID_AND_PAYLOAD_TYPE 3'h2
`define LTF_WAKE_FRAME_TYPE 3'h3
`define LTF_ERROR_CONDITION_TYPE 3'h4
// Operators
`define LTF_EQUAL_OP 3'h0
`define LTF_NOT_EQUAL_OP 3'h1
`define LTF_LESS_OP 3'h2
`define LTF_LESS_EQUAL_OP 3'h3
`define LTF_GREATER_OP 3'h4
`define LTF_GREATER_EQUAL_OP 3'h5
`define LTF_WITHIN_BOUNDS_OP 3'h6
`define LTF_OUTSIDE_BOUNDS_OP 3'h7
// Fields
`define LTF_CHECKSUM_FAULT_BIT 0
`define LTF_ID_PARITY_FAULT_BIT 1
`define LTF_SYNC_FAULT_BIT 2
`define LTF_CMD_SELECT_ALL_BIT 0
`define LTF_CMD_DESELECT_ALL_BIT 1
`define LTF_CMD_INVERT_BIT 2
`define LTF_CMD_RESET_BIT 3
`define LTF_SKIP_MSB 12
`define LTF_LEN_LSB 16
// Reset values
`define LTF_ERR_EN_RST 3'h7
`define LTF_SKIP_RST 13'h0001
`define LTF_LEN_RST 2'h0
`define LTF_ID_LOW_RST 6'h00
`define LTF_ID_HIGH_RST 6'h3F
`define LTF_FLT_EN_RST 16'hFFFF
`endif

// ### test/ltf_chk.sv
// Purpose: Port checks of bus wait states, trigger strobes and filter verdicts
// Assumes: hready is fed back from hreadyout
// Notes: Bound into the top module
module ltf_chk #(
  parameter NB = 4
) (
  input logic core_clk,
  input logic rst,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [NB-1:0] dec_sync_stop,
  input logic [NB-1:0] dec_id_valid,
  input logic [NB-1:0] dec_data_valid,
  input logic [NB-1:0] dec_wake,
  input logic [NB-1:0] dec_chk_err,
  input logic [NB-1:0] dec_par_err,
  input logic [NB-1:0] dec_sync_err,
  input logic [NB-1:0] dec_frame_end,
  input logic trig_pulse,
  input logic [NB-1:0] frame_pass,
  input logic [NB-1:0] frame_pass_valid,
  input logic [NB-1:0] idle_low_polarity
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic wr_q;
  wire [NB-1:0] evt = dec_sync_stop | dec_id_valid | dec_data_valid | dec_wake |
    dec_chk_err | dec_par_err | dec_sync_err;
  // Marks the data phase of a taken write
  always @(posedge core_clk) begin
    wr_q <= !rst && hsel && htrans[1] && hready && hwrite;
  end
  // Read address phase and its single wait state
  sequence rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_rd_wait: assert property (rd_take |=> one_wait) else $error("bad read wait");
  chk_wait_cause: assert property (!hreadyout |-> $past(hsel && htrans[1] && hready && !hwrite))
    else $error("stray wait state");
  chk_resp_okay: assert property (!hresp) else $error("response not okay");
  chk_trig_single: assert property (trig_pulse |=> !trig_pulse) else $error("long trig");
  chk_trig_cause: assert property (trig_pulse |-> $past(|evt)) else $error("trig no cause");
  chk_pass_valid: assert property (frame_pass_valid == $past(dec_frame_end))
    else $error("verdict strobe off");
  chk_pass_hold: assert property ($changed(frame_pass) |-> frame_pass_valid != 0)
    else $error("verdict moved");
  chk_pol_write: assert property ($changed(idle_low_polarity) |-> $past(wr_q))
    else $error("polarity moved");
endmodule
bind ltf_top ltf_chk #(.NB(NB)) ltf_chk_i (.core_clk(core_clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .dec_sync_stop(dec_sync_stop), .dec_id_valid(dec_id_valid), .dec_data_valid(dec_data_valid),
  .dec_wake(dec_wake), .dec_chk_err(dec_chk_err), .dec_par_err(dec_par_err),
  .dec_sync_err(dec_sync_err), .dec_frame_end(dec_frame_end), .trig_pulse(trig_pulse),
  .frame_pass(frame_pass), .frame_pass_valid(frame_pass_valid),
  .idle_low_polarity(idle_low_polarity));

// ### test/ltf_dec_model.sv
// Purpose: Frame decoder model issuing one-cycle event strobes
// Assumes: Kind 0 sync stop,1 id,2 data,3 wake,4 checksum,5 parity,6 sync,7 frame end
// Notes: Value lines show the inverse of the last value once released
module ltf_dec_model (
  input logic core_clk,
  output logic [7:0][3:0] pl,
  output logic [31:0] idb,
  output logic [31:0] db,
  output logic [11:0] ft,
  output logic [31:0] fe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quiet strobes at start
  initial begin
    pl = '0;
    idb = '0;
    db = '0;
    ft = '0;
    fe = '0;
  end
  // One strobe with its values, after an optional stall
  task automatic ev(input int b, k, input logic [7:0] v, er, input int gap);
    repeat (gap + 1) @(posedge core_clk);
    pl[k][b] <= 1'b1;
    idb[8*b+:8] <= v;
    db[8*b+:8] <= v;
    ft[3*b+:3] <= v[2:0];
    fe[8*b+:8] <= er;
    @(posedge core_clk);
    pl[k][b] <= 1'b0;
    idb[8*b+:8] <= ~v;
    db[8*b+:8] <= ~v;
    ft[3*b+:3] <= ~v[2:0];
    fe[8*b+:8] <= ~er;
  endtask
endmodule

// ### test/lin_trigger_and_filter_bench.sv
// Purpose: Self-checking bench of the LIN trigger and filter block
// Assumes: Writes take no wait state, reads one
// Notes: Trigger pulses are counted by a monitor and compared per scenario
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module lin_trigger_and_filter_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'h7419, r;
  logic hreadyout, hresp, trig_pulse;
  logic [3:0] frame_pass, frame_pass_valid, idle_low_polarity, fpv;
  logic [7:0][3:0] pl;
  logic [31:0] idb, db, fe;
  logic [11:0] ft;
  int err_total, checks, tcnt, tx, cyc;
  logic [7:0] ra [12] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40, 8'h50,
    8'h60, 8'h70, 8'hA0};
  logic [31:0] rv [12] = '{32'h0, 32'h7, 32'h0, 32'h1, 32'h0, 32'h0, 32'h3F, 32'hFFFF,
    32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h0};
  ltf_top #(.NB(4), .NFT(8), .NET(8)) ltf_top_i (.core_clk(core_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dec_sync_stop(pl[0]), .dec_id_valid(pl[1]), .dec_id(idb),
    .dec_data_valid(pl[2]), .dec_data(db), .dec_wake(pl[3]), .dec_chk_err(pl[4]),
    .dec_par_err(pl[5]), .dec_sync_err(pl[6]), .dec_frame_end(pl[7]),
    .dec_frame_type(ft), .dec_frame_errs(fe), .trig_pulse(trig_pulse),
    .frame_pass(frame_pass), .frame_pass_valid(frame_pass_valid),
    .idle_low_polarity(idle_low_polarity));
  ltf_dec_model ltf_dec_model_i (.core_clk(core_clk), .pl(pl), .idb(idb), .db(db),
    .ft(ft), .fe(fe));
  always #12.5 core_clk = ~core_clk;
  // Trigger counter, verdict capture and timeout
  always @(posedge core_clk) begin
    cyc++;
    if (trig_pulse === 1'b1) tcnt++;
    if (|frame_pass_valid) fpv <= frame_pass;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Relation of a received value to the pattern and bound
  function automatic bit rel(input logic [2:0] o, input logic [31:0] a, l, h);
    case (o)
      3'h0: return a == l;
      3'h1: return a != l;
      3'h2: return a < l;
      3'h3: return a <= l;
      3'h4: return a > l;
      3'h5: return a >= l;
      3'h6: return a >= l && a <= h;
      default: return a < l || a > h;
    endcase
  endfunction
  // One single transfer, read data left in r
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rc(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    `CK("reg", e, r)
  endtask
  task automatic e(input int b, k, input logic [7:0] v);
    ltf_dec_model_i.ev(b, k, v, 8'h00, rnd() % 3);
  endtask
  task automatic tr(input bit x);
    repeat (2) @(posedge core_clk);
    tx += x;
    `CK("trig", tx, tcnt)
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    int s, b, i, k, op, lo, hi, n, len;
    logic [31:0] a, p, m;
    logic [7:0] v, id;
    bit x;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values, one unmapped place among them
    foreach (ra[i]) rc({24'h0, ra[i]}, rv[i]);
    `CK("pol", 4'h0, idle_low_polarity)
    // Start of frame on the selected bus only
    s = rnd() % 4;
    bus(1'b1, 32'h20, s);
    for (b = 0; b < 4; b++) begin
      e(b, 0, 8'h00);
      tr(b == s);
    end
    e(s, 3, 8'h00);
    tr(1'b0);
    // Identifier relations, parity bits random
    bus(1'b1, 32'h00, 32'h1);
    for (op = 0; op < 8; op++) begin
      lo = rnd() % 64;
      hi = lo + rnd() % (64 - lo);
      bus(1'b1, 32'h14, op);
      bus(1'b1, 32'h18, lo);
      bus(1'b1, 32'h1C, hi);
      for (i = 0; i < 4; i++) begin
        id = (i == 0) ? {2'h3, lo[5:0]} : rnd() % 256;
        e(s, 0, 8'h00);
        e(s, 1, id);
        tr(rel(op, id[5:0], lo, hi));
      end
    end
    // Status word ignores writes and reports last identifier and trigger count
    bus(1'b1, 32'h24, 32'h0);
    rc(32'h24, {10'h000, id[5:0], tx[15:0]});
    // Identifier plus payload over the compared bytes
    bus(1'b1, 32'h00, 32'h2);
    bus(1'b1, 32'h14, 32'h0);
    for (op = 0; op < 8; op++) begin
      n = 1 + rnd() % 3;
      len = rnd() % 4;
      p = rnd();
      bus(1'b1, 32'h08, op);
      bus(1'b1, 32'h0C, p);
      bus(1'b1, 32'h10, n | len << 16);
      for (k = 0; k < 2; k++) begin
        x = rnd() % 2;
        e(s, 0, 8'h00);
        e(s, 1, {2'h0, lo[5:0] ^ {5'h0, !x}});
        a = 0;
        m = 0;
        for (i = 0; i < n + len + 1; i++) begin
          v = rnd() % 256;
          if (i >= n && rnd() % 2) v = p[8*(i-n)+:8];
          if (i >= n) a = {a[23:0], v};
          if (i >= n) m = {m[23:0], p[8*(i-n)+:8]};
          e(s, 2, v);
        end
        tr(x && op < 6 && rel(op, a, m, 32'h0));
      end
    end
    bus(1'b1, 32'h10, 32'h1000);
    rc(32'h10, 32'h1000);
    // Error types with each enable dropped in turn, then wake
    bus(1'b1, 32'h00, 32'h4);
    for (k = 4; k < 7; k++)
      for (i = 0; i < 2; i++) begin
        bus(1'b1, 32'h04, i ? 32'h7 ^ (32'h1 << (k - 4)) : 32'h7);
        e(s, k, 8'h00);
        tr(i == 0);
      end
    bus(1'b1, 32'h00, 32'h3);
    e(s, 3, 8'h00);
    tr(1'b1);
    // Filter commands, index writes, verdicts and polarity per bus
    for (b = 0; b < 4; b++) begin
      a = 32'h40 + 16 * b;
      bus(1'b1, a + 4, 32'h2);
      rc(a, 32'h0);
      rc(a ^ 32'h10, 32'hFFFF);
      k = rnd() % 8;
      m = (32'h1 << k) | (32'h100 << (7 - k));
      bus(1'b1, a + 8, 32'h10000 | k);
      bus(1'b1, a + 8, 32'h10100 | (7 - k));
      rc(a, m);
      bus(1'b1, a + 4, 32'h4);
      rc(a, 32'hFFFF ^ m);
      bus(1'b1, a + 4, 32'h1);
      rc(a, 32'hFFFF);
      m = rnd() % 65536;
      bus(1'b1, a, m);
      for (i = 0; i < 4; i++) begin
        k = rnd() % 8;
        v = i % 2 ? rnd() % 256 : 8'h00;
        ltf_dec_model_i.ev(b, 7, k, v, 0);
        repeat (2) @(posedge core_clk);
        `CK("pass", m[k] && (v == 0 || |(v & m[15:8])), fpv[b])
      end
      bus(1'b1, a + 4, 32'hC);
      rc(a, 32'hFFFF);
      bus(1'b1, a + 12, 32'h1);
      @(posedge core_clk);
      `CK("pol", 4'hF >> (3 - b), idle_low_polarity)
    end
    report_and_stop();
  end
endmodule
